// ===== src/tap_scan_chain_extension_port.v
// tap controller with state, instruction and scan chain observation outputs
`timescale 1ns/100ps
`include "tap_ext_defines.vh"
// What this block does
// - tap_instr_out shows the held instruction and updates in the update-dr and test-logic-reset states.
// - selected_chain_id shows the selected chain and changes in the update-dr and test-logic-reset states.
// - tap_state_out shows the controller state and changes only on test clock steps and on a low test_reset_n.
// - capture_state_flag is high exactly in a capture state.
// - shift_state_flag is high exactly in a shift state.
// - update_state_flag is high exactly in an update state.
// - capture, shift, update, intest and extest flags are active only with chain 0 selected.
// - ext_chain_serial_out carries the serial data for the external chain.
// - ext_chain_serial_return is routed onto the single test data output except in shift-ir and while IR_IDCODE, IR_SCAN_N or IR_BYPASS is held.
// - a low test_reset_n resets the controller state, the held instruction and the chain number.
// - ref_clk_i is the only clock; test timing comes from enables.
module tap_scan_chain_extension_port (
    input wire ref_clk_i,
    input wire rstn_i,
    input wire test_reset_n_i,
    input wire test_clock_enable_i,
    input wire test_mode_select_i,
    input wire test_serial_in_i,
    input wire ext_chain_serial_return_i,
    output reg [3:0] tap_instr_out_o,
    output reg [3:0] selected_chain_id_o,
    output reg [3:0] tap_state_out_o,
    output reg capture_state_flag_o,
    output reg shift_state_flag_o,
    output reg update_state_flag_o,
    output reg internal_test_flag_o,
    output reg external_test_flag_o,
    output reg ext_chain_serial_out_o,
    output reg test_serial_out_o,
    output reg test_out_enable_n_o
);

    // pin synchronisers
    reg [1:0] trst_sync;
    reg [1:0] tcken_sync;
    reg [1:0] tms_sync;
    reg [1:0] tdi_sync;
    reg [1:0] ret_sync;
    wire trst_n = trst_sync[1];
    wire step = tcken_sync[1];
    wire tms = tms_sync[1];
    wire tdi = tdi_sync[1];
    wire ret = ret_sync[1];

    reg [3:0] state;
    reg [3:0] next_state;
    reg [3:0] ir_shift;
    reg [3:0] chain_shift;
    reg [31:0] id_shift;
    reg bypass_bit;
    reg [3:0] ir;
    reg [3:0] chain;
    reg next_tdo;
    reg [3:0] next_instr_out;
    reg next_capture_flag;
    reg next_shift_flag;
    reg next_update_flag;
    reg next_intest_flag;
    reg next_extest_flag;
    reg next_out_enable_n;

    // capture-dr or capture-ir
    function is_capture;
        input [3:0] code;
        begin
            is_capture = (code == `ST_CAP_DR) || (code == `ST_CAP_IR);
        end
    endfunction

    // shift-dr or shift-ir
    function is_shift;
        input [3:0] code;
        begin
            is_shift = (code == `ST_SHIFT_DR) || (code == `ST_SHIFT_IR);
        end
    endfunction

    // update-dr or update-ir
    function is_update;
        input [3:0] code;
        begin
            is_update = (code == `ST_UPD_DR) || (code == `ST_UPD_IR);
        end
    endfunction

    // scan chain 0 selected
    function is_chain_zero;
        input [3:0] id;
        begin
            is_chain_zero = (id == `CHAIN_ZERO);
        end
    endfunction

    // instruction selects the chain number register
    function is_scan_n;
        input [3:0] code;
        begin
            is_scan_n = (code == `IR_SCAN_N);
        end
    endfunction

    // states in which the instruction view is refreshed
    function shows_instr;
        input [3:0] code;
        begin
            shows_instr = (code == `ST_UPD_DR) || (code == `ST_RESET);
        end
    endfunction

    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trst_sync <= 2'h0;
            tcken_sync <= 2'h0;
            tms_sync <= 2'h3;
            tdi_sync <= 2'h0;
            ret_sync <= 2'h0;
        end else begin
            trst_sync <= {trst_sync[0], test_reset_n_i};
            tcken_sync <= {tcken_sync[0], test_clock_enable_i};
            tms_sync <= {tms_sync[0], test_mode_select_i};
            tdi_sync <= {tdi_sync[0], test_serial_in_i};
            ret_sync <= {ret_sync[0], ext_chain_serial_return_i};
        end
    end

    // state transition
    always @* begin
        case (state)
            `ST_RESET: next_state = tms ? `ST_RESET : `ST_IDLE;
            `ST_IDLE: next_state = tms ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_DR: next_state = tms ? `ST_SEL_IR : `ST_CAP_DR;
            `ST_CAP_DR: next_state = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
            `ST_SHIFT_DR: next_state = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
            `ST_EXIT1_DR: next_state = tms ? `ST_UPD_DR : `ST_PAUSE_DR;
            `ST_PAUSE_DR: next_state = tms ? `ST_EXIT2_DR : `ST_PAUSE_DR;
            `ST_EXIT2_DR: next_state = tms ? `ST_UPD_DR : `ST_SHIFT_DR;
            `ST_UPD_DR: next_state = tms ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_IR: next_state = tms ? `ST_RESET : `ST_CAP_IR;
            `ST_CAP_IR: next_state = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
            `ST_SHIFT_IR: next_state = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
            `ST_EXIT1_IR: next_state = tms ? `ST_UPD_IR : `ST_PAUSE_IR;
            `ST_PAUSE_IR: next_state = tms ? `ST_EXIT2_IR : `ST_PAUSE_IR;
            `ST_EXIT2_IR: next_state = tms ? `ST_UPD_IR : `ST_SHIFT_IR;
            `ST_UPD_IR: next_state = tms ? `ST_SEL_DR : `ST_IDLE;
            default: next_state = `ST_RESET;
        endcase
    end

    // controller state, one move per enabled step
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= `ST_RESET;
        end else if (!trst_n) begin
            state <= `ST_RESET;
        end else if (step) begin
            state <= next_state;
        end
    end

    // instruction shift and hold registers
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ir_shift <= 4'h0;
            ir <= `IR_RESET_VAL;
        end else if (!trst_n) begin
            ir <= `IR_RESET_VAL;
        end else if (step) begin
            case (state)
                `ST_RESET: ir <= `IR_RESET_VAL;
                `ST_CAP_IR: ir_shift <= 4'h1;
                `ST_SHIFT_IR: ir_shift <= {tdi, ir_shift[3:1]};
                `ST_UPD_IR: ir <= ir_shift;
                default: ir_shift <= ir_shift;
            endcase
        end
    end

    // data registers and chain number
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            chain_shift <= 4'h0;
            id_shift <= 32'h0000_0000;
            bypass_bit <= 1'b0;
            chain <= `CHAIN_RESET_VAL;
        end else if (!trst_n) begin
            chain <= `CHAIN_RESET_VAL;
        end else if (step) begin
            case (state)
                `ST_RESET: chain <= `CHAIN_RESET_VAL;
                `ST_CAP_DR: begin
                    id_shift <= `IDCODE_VAL;
                    bypass_bit <= 1'b0;
                    chain_shift <= chain;
                end
                `ST_SHIFT_DR: begin
                    id_shift <= {tdi, id_shift[31:1]};
                    bypass_bit <= tdi;
                    chain_shift <= {tdi, chain_shift[3:1]};
                end
                `ST_UPD_DR: begin
                    if (is_scan_n(ir)) begin
                        chain <= chain_shift;
                    end
                end
                default: begin
                    bypass_bit <= bypass_bit;
                end
            endcase
        end
    end

    // serial data routed to the single test data output
    always @* begin
        if (state == `ST_SHIFT_IR) begin
            next_tdo = ir_shift[0];
        end else if (ir == `IR_IDCODE) begin
            next_tdo = id_shift[0];
        end else if (is_scan_n(ir)) begin
            next_tdo = chain_shift[0];
        end else if (ir == `IR_BYPASS) begin
            next_tdo = bypass_bit;
        end else begin
            next_tdo = ret;
        end
    end

    // instruction view follows ir only in update-dr or test-logic-reset
    always @* begin
        if (shows_instr(state)) begin
            next_instr_out = ir;
        end else begin
            next_instr_out = tap_instr_out_o;
        end
    end

    // decoded flags, gated by chain 0, and the ungated output enable
    always @* begin
        next_capture_flag = is_chain_zero(chain) && is_capture(state);
        next_shift_flag = is_chain_zero(chain) && is_shift(state);
        next_update_flag = is_chain_zero(chain) && is_update(state);
        next_intest_flag = is_chain_zero(chain) && (next_instr_out == `IR_INTEST);
        next_extest_flag = is_chain_zero(chain) && (next_instr_out == `IR_EXTEST);
        next_out_enable_n = !is_shift(state);
    end

    // instruction view
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tap_instr_out_o <= `IR_RESET_VAL;
        end else begin
            tap_instr_out_o <= next_instr_out;
        end
    end

    // chain number and controller state view
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            selected_chain_id_o <= `CHAIN_RESET_VAL;
            tap_state_out_o <= `ST_RESET;
        end else begin
            selected_chain_id_o <= chain;
            tap_state_out_o <= state;
        end
    end

    // chain-0 gated state and test flags
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            capture_state_flag_o <= 1'b0;
            shift_state_flag_o <= 1'b0;
            update_state_flag_o <= 1'b0;
            internal_test_flag_o <= 1'b0;
            external_test_flag_o <= 1'b0;
        end else begin
            capture_state_flag_o <= next_capture_flag;
            shift_state_flag_o <= next_shift_flag;
            update_state_flag_o <= next_update_flag;
            internal_test_flag_o <= next_intest_flag;
            external_test_flag_o <= next_extest_flag;
        end
    end

    // serial data towards the external chain
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_chain_serial_out_o <= 1'b0;
        end else begin
            ext_chain_serial_out_o <= tdi;
        end
    end

    // test data output and its enable
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            test_serial_out_o <= 1'b0;
            test_out_enable_n_o <= 1'b1;
        end else begin
            if (step) begin
                test_serial_out_o <= next_tdo;
            end
            test_out_enable_n_o <= next_out_enable_n;
        end
    end

endmodule // tap_scan_chain_extension_port

// ===== src/tap_ext_defines.vh
// constants for the tap observation and extension port
`ifndef TAP_EXT_DEFINES_VH
`define TAP_EXT_DEFINES_VH
`define ST_RESET      4'hF
`define ST_IDLE       4'hC
`define ST_SEL_DR     4'h7
`define ST_CAP_DR     4'h6
`define ST_SHIFT_DR   4'h2
`define ST_EXIT1_DR   4'h1
`define ST_PAUSE_DR   4'h3
`define ST_EXIT2_DR   4'h0
`define ST_UPD_DR     4'h5
`define ST_SEL_IR     4'h4
`define ST_CAP_IR     4'hE
`define ST_SHIFT_IR   4'hA
`define ST_EXIT1_IR   4'h9
`define ST_PAUSE_IR   4'hB
`define ST_EXIT2_IR   4'h8
`define ST_UPD_IR     4'hD
`define IR_EXTEST     4'h0
`define IR_SCAN_N     4'h2
`define IR_INTEST     4'hC
`define IR_IDCODE     4'hE
`define IR_BYPASS     4'hF
`define IR_RESET_VAL  4'hE
`define CHAIN_RESET_VAL 4'h0
`define CHAIN_ZERO    4'h0
`define IDCODE_VAL    32'h0000_0001 // arbitrary id value
`endif

// ===== testbench/ext_chain_model.sv
// external scan chain model
`timescale 1ns/100ps
module ext_chain_model (
    input clk_i,
    input on_i,
    input sh_i,
    input d_i,
    output q_o
);
    reg [3:0] sr = 4'h0;
    always @(posedge clk_i) if (sh_i) sr <= {sr[2:0], d_i};
    assign q_o = on_i & sr[3];
endmodule // ext_chain_model

// ===== testbench/tap_scan_chain_extension_port_chk.sv
// assertions on the tap port outputs
`timescale 1ns/100ps
module tap_port_chk (
    input ref_clk_i,
    input rstn_i,
    input test_reset_n_i,
    input test_clock_enable_i,
    input [3:0] tap_instr_out_o,
    input [3:0] selected_chain_id_o,
    input [3:0] tap_state_out_o,
    input capture_state_flag_o,
    input shift_state_flag_o,
    input update_state_flag_o,
    input internal_test_flag_o,
    input external_test_flag_o,
    input test_out_enable_n_o
);
    wire c0 = selected_chain_id_o == 4'h0;
    wire [3:0] s = tap_state_out_o;
    wire [3:0] r = tap_instr_out_o;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    a_cap_flag: assert property (
        capture_state_flag_o == (c0 && (s == 4'h6 || s == 4'hE))) else $error("cap");
    a_shift_flag: assert property (
        shift_state_flag_o == (c0 && (s == 4'h2 || s == 4'hA))) else $error("shift");
    a_update_flag: assert property (
        update_state_flag_o == (c0 && (s == 4'h5 || s == 4'hD))) else $error("upd");
    a_intest_flag: assert property (
        internal_test_flag_o == (c0 && r == 4'hC)) else $error("it");
    a_extest_flag: assert property (
        external_test_flag_o == (c0 && r == 4'h0)) else $error("et");
    a_oe_in_shift: assert property (
        test_out_enable_n_o == !(s == 4'h2 || s == 4'hA)) else $error("oe");
    a_hold_no_step: assert property (
        (test_reset_n_i && !test_clock_enable_i) [*5] |=> $stable(s)) else $error("moved");
    a_instr_on_update: assert property ($changed(r) |->
        s == 4'h5 || s == 4'hF) else $error("instr");
    cover property (capture_state_flag_o);
    cover property (internal_test_flag_o);
    cover property (!test_out_enable_n_o);
endmodule // tap_port_chk
bind tap_scan_chain_extension_port tap_port_chk u_chk (.*);

// ===== testbench/tap_scan_chain_extension_port_tb_top.sv
// self-checking bench for the tap port
`timescale 1ns/100ps
module tap_scan_chain_extension_port_tb_top;
    reg clk = 0, rstn = 0, trst = 1, en = 0, tms = 0, tdi = 0, pres = 1;
    wire ret, cf, sf, uf, itf, etf, so, tdo, oen;
    wire [3:0] ir, ch, st;
    integer num_errors = 0, compares = 0, seed = 77, i, j, k;
    reg [3:0] chain = 4'h0, v, w, held = 4'hE, shown = 4'hE;
    always #12.5 clk = ~clk;
    tap_scan_chain_extension_port u_dut (.ref_clk_i(clk), .rstn_i(rstn), .test_reset_n_i(trst),
        .test_clock_enable_i(en), .test_mode_select_i(tms), .test_serial_in_i(tdi),
        .ext_chain_serial_return_i(ret), .tap_instr_out_o(ir), .selected_chain_id_o(ch),
        .tap_state_out_o(st), .capture_state_flag_o(cf), .shift_state_flag_o(sf),
        .update_state_flag_o(uf), .internal_test_flag_o(itf), .external_test_flag_o(etf),
        .ext_chain_serial_out_o(so), .test_serial_out_o(tdo), .test_out_enable_n_o(oen));
    ext_chain_model u_chain (.clk_i(clk), .on_i(pres), .sh_i(en & ~oen), .d_i(so), .q_o(ret));
    task chk(input [11:0] a, input [11:0] b);
        compares = compares + 1;
        if (a !== b) begin
            num_errors = num_errors + 1;
            $display("Error %0t %h %h", $time, a, b);
        end
    endtask
    task finish_test;
        if (num_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task step(input [2:0] m, input [1:0] n, input d);
        for (k = 0; k < n; k = k + 1) begin
            @(negedge clk);
            tms = m[k];
            tdi = d;
            en = 1;
            @(negedge clk);
            en = 0;
            repeat (4) @(negedge clk);
        end
    endtask
    task scan(input t, input [3:0] val, input [3:0] n, input e);
        step(t ? 3'h3 : 3'h1, t ? 2'h3 : 2'h2, 0);
        chk(cf, chain == 0);
        step(0, 1, 0);
        chk({sf, oen}, {chain == 4'h0, 1'b0});
        for (i = 0; i < n; i = i + 1) begin
            step(i == n - 1, 1, val[i % 4]);
            chk(so, val[i % 4]);
            if (i == 6) chk(tdo, e);
        end
        step(1, 1, 0);
        if (t) chk(uf, chain == 0);
        chk(oen, 1'b1);
        step(0, 1, 0);
        if (t) held = val;
        else shown = held;
        chk(ir, shown);
        if (t) begin
            step(3'h5, 2'h3, 0);
            step(3'h1, 2'h2, 0);
            shown = held;
            chk(ir, shown);
        end
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rstn = 1;
        repeat (4) @(negedge clk);
        step(0, 1, 0);
        chk(st, 4'hC);
        v = $random(seed);
        for (j = 0; j < 3; j = j + 1) begin
            w = j == 0 ? 4'h0 : j == 1 ? 4'hC : {1'b0, v[1:0], 1'b1};
            scan(1, w, 4, 0);
            chk({itf, etf}, {w == 4'hC, w == 4'h0});
        end
        scan(0, 4'hF, 8, 1);
        pres = 0;
        scan(0, 4'hF, 8, 0);
        scan(1, 4'h2, 4, 0);
        scan(0, 4'h3, 4, 0);
        chain = 4'h3;
        scan(1, 4'hC, 4, 0);
        chk({ch, 3'h0, itf}, 8'h30);
        scan(1, 4'hF, 4, 0);
        scan(0, 4'h2, 8, 1);
        trst = 0;
        repeat (4) @(negedge clk);
        trst = 1;
        repeat (4) @(negedge clk);
        chk({st, ir, ch}, 12'hFE0);
        finish_test;
    end
endmodule // tap_scan_chain_extension_port_tb_top
